// ---- cpu_regs_pkg.sv ----
package cpu_regs_pkg;

// ------------------------------------------------------------
// register file geometry
// ------------------------------------------------------------
localparam int INT_REGS = 32;
localparam int FP_REGS = 32;
localparam int WORD_W = 32;
localparam int FP_LANES = 4;

// ------------------------------------------------------------
// operand sizes
// ------------------------------------------------------------
typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
} mem_size_t;

typedef enum logic [1:0] {
    FP_32 = 2'h0,
    FP_64 = 2'h1,
    FP_128 = 2'h2
} fp_size_t;

localparam logic [1:0] PIX_8 = 2'h0;
localparam logic [1:0] PIX_16 = 2'h1;
localparam logic [1:0] PIX_32 = 2'h2;

// ------------------------------------------------------------
// floating-point field decode
// ------------------------------------------------------------
localparam int SP_SIGN = 31;
localparam int SP_EXP_LO = 23;
localparam int SP_EXP_W = 8;
localparam logic [7:0] SP_EXP_MAX = 8'hff;
localparam int DP_SIGN = 63;
localparam int DP_EXP_LO = 52;
localparam int DP_EXP_W = 11;
localparam logic [10:0] DP_EXP_MAX = 11'h7ff;

// ------------------------------------------------------------
// processor state word layout
// ------------------------------------------------------------
localparam int PSW_LOAD_MATCH = 0;
localparam int PSW_STORE_MATCH = 1;
localparam int PSW_COND = 2;
localparam int PSW_LOOP = 3;
localparam int PSW_IRQ_EN = 4;
localparam int PSW_PRIOR_IRQ = 5;
localparam int PSW_USER = 6;
localparam int PSW_PRIOR_USER = 7;
localparam int PSW_EXT_IRQ = 8;
localparam int PSW_OPCODE_TRAP = 9;
localparam int PSW_FETCH_TRAP = 10;
localparam int PSW_OPERAND_TRAP = 11;
localparam int PSW_FP_TRAP = 12;
localparam int PSW_DEFER_SWAP = 13;
localparam int PSW_DUAL = 14;
localparam int PSW_SKIP_FP = 15;
localparam int PSW_SHIFT_LO = 17;
localparam int PSW_SHIFT_W = 5;
localparam int PSW_PIX_LO = 22;
localparam int PSW_MASK_LO = 24;
localparam int PSW_MASK_W = 8;
localparam logic [31:0] PSW_RESET = 32'h0000_0000;
localparam logic [31:0] PSW_USER_WMASK = 32'h0000_000c;
localparam logic [31:0] PSW_RSVD_MASK = 32'h0001_0000;
localparam logic [31:0] WATCH_RESET = 32'h0000_0000;

endpackage

// ---- regfile_mem.sv ----
`timescale 1ns/1ns
`default_nettype none

module regfile_mem #(
    parameter int WORDS = 32,
    parameter int LANES = 1,
    parameter int LANE_W = 32,
    parameter logic [LANES-1:0] ZERO_LANES = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS)-1:0] wr_addr,
    input wire logic [LANES-1:0] wr_lane,
    input wire logic [LANES*LANE_W-1:0] wr_data,
    input wire logic [$clog2(WORDS)-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data
);

generate
    if (WORDS < 2 || LANES < 1 || LANE_W < 1) begin : g_bad
        $error("regfile_mem: unsupported geometry");
    end
endgenerate

logic [LANES*LANE_W-1:0] mem [WORDS];

// ------------------------------------------------------------
// lane-masked write
// ------------------------------------------------------------
always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
        if (wr_en && wr_lane[l]) begin
            mem[wr_addr][l*LANE_W +: LANE_W] <= wr_data[l*LANE_W +: LANE_W];
        end
    end
end

// ------------------------------------------------------------
// registered read, hardwired zero lanes in row 0
// ------------------------------------------------------------
always_ff @(posedge clk) begin
    if (!nrst) begin
        rd_data <= '0;
    end else begin
        for (int l = 0; l < LANES; l++) begin
            if (rd_addr == '0 && ZERO_LANES[l]) begin
                rd_data[l*LANE_W +: LANE_W] <= '0;
            end else begin
                rd_data[l*LANE_W +: LANE_W] <= mem[rd_addr][l*LANE_W +: LANE_W];
            end
        end
    end
end

endmodule

`default_nettype wire

// ---- cpu_register_set_status.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpu_register_set_status (
    input wire logic clk,
    input wire logic nrst,
    input wire logic int_wr_en,
    input wire logic [4:0] int_wr_addr,
    input wire logic [1:0] int_wr_size,
    input wire logic [31:0] int_wr_data,
    input wire logic [4:0] int_rd_addr,
    output logic [31:0] int_rd_data,
    input wire logic store_req,
    input wire logic [1:0] store_size,
    output logic store_valid,
    output logic [31:0] store_data,
    input wire logic fp_wr_en,
    input wire logic [4:0] fp_wr_addr,
    input wire logic [1:0] fp_wr_size,
    input wire logic [127:0] fp_wr_data,
    input wire logic fp_rd_req,
    input wire logic [4:0] fp_rd_addr,
    input wire logic [1:0] fp_rd_size,
    input wire logic fp_rd_check,
    output logic fp_rd_valid,
    output logic [127:0] fp_rd_data,
    output logic fp_src_exc,
    input wire logic ctrl_wr_en,
    input wire logic ctrl_wr_sel,
    input wire logic [31:0] ctrl_wr_data,
    output logic [31:0] processor_state_word,
    output logic [31:0] watch_address_reg,
    output logic ctrl_wr_blocked,
    output logic privilege_user,
    input wire logic ext_irq_pin,
    input wire logic parity_err,
    input wire logic bus_fault_pin,
    output logic irq_request,
    input wire logic trap_take,
    input wire logic [3:0] trap_cause,
    input wire logic dual_mode_now,
    input wire logic mode_change_next,
    input wire logic trap_return,
    output logic resume_dual,
    output logic resume_swap,
    input wire logic fp_issue,
    input wire logic fp_issue_dual,
    output logic fp_kill,
    output logic fp_kill_dual,
    input wire logic rshift_exec,
    input wire logic [4:0] rshift_count,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [1:0] acc_size,
    input wire logic [31:0] acc_addr,
    output logic acc_match_trap,
    input wire logic pix_store_req,
    output logic [7:0] pix_byte_en
);

// ------------------------------------------------------------
// integer register file
// ------------------------------------------------------------
logic [31:0] next_int_wr_data;
logic [31:0] int_mem_q;

always_comb begin
    case (int_wr_size)
        cpu_regs_pkg::SZ_BYTE: next_int_wr_data = {{24{int_wr_data[7]}},
            int_wr_data[7:0]};
        cpu_regs_pkg::SZ_HALF: next_int_wr_data = {{16{int_wr_data[15]}},
            int_wr_data[15:0]};
        default: next_int_wr_data = int_wr_data;
    endcase
end

regfile_mem #(
    .WORDS(cpu_regs_pkg::INT_REGS),
    .LANES(1),
    .LANE_W(cpu_regs_pkg::WORD_W),
    .ZERO_LANES(1'b1)
) u_int_file (
    .clk(clk),
    .nrst(nrst),
    .wr_en(int_wr_en),
    .wr_addr(int_wr_addr),
    .wr_lane(1'b1),
    .wr_data(next_int_wr_data),
    .rd_addr(int_rd_addr),
    .rd_data(int_mem_q)
);

assign int_rd_data = int_mem_q;

// ------------------------------------------------------------
// store truncation
// ------------------------------------------------------------
logic st_pend;
logic [1:0] st_size_q;

always_ff @(posedge clk) begin
    if (!nrst) begin
        st_pend <= 1'b0;
        st_size_q <= cpu_regs_pkg::SZ_WORD;
        store_valid <= 1'b0;
        store_data <= 32'h0000_0000;
    end else begin
        st_pend <= store_req;
        st_size_q <= store_size;
        store_valid <= st_pend;
        case (st_size_q)
            cpu_regs_pkg::SZ_BYTE: store_data <= {24'h00_0000,
                int_mem_q[7:0]};
            cpu_regs_pkg::SZ_HALF: store_data <= {16'h0000,
                int_mem_q[15:0]};
            default: store_data <= int_mem_q;
        endcase
    end
end

// ------------------------------------------------------------
// floating-point register file
// ------------------------------------------------------------
logic [3:0] fp_wr_lane;
logic [127:0] fp_wr_lanes;
logic [127:0] fp_mem_q;

always_comb begin
    case (fp_wr_size)
        cpu_regs_pkg::FP_32: begin
            fp_wr_lane = 4'h1 << fp_wr_addr[1:0];
            fp_wr_lanes = {4{fp_wr_data[31:0]}};
        end
        cpu_regs_pkg::FP_64: begin
            fp_wr_lane = fp_wr_addr[1] ? 4'hc : 4'h3;
            fp_wr_lanes = {2{fp_wr_data[63:0]}};
        end
        default: begin
            fp_wr_lane = 4'hf;
            fp_wr_lanes = fp_wr_data;
        end
    endcase
end

regfile_mem #(
    .WORDS(cpu_regs_pkg::FP_REGS / cpu_regs_pkg::FP_LANES),
    .LANES(cpu_regs_pkg::FP_LANES),
    .LANE_W(cpu_regs_pkg::WORD_W),
    .ZERO_LANES(4'h3)
) u_fp_file (
    .clk(clk),
    .nrst(nrst),
    .wr_en(fp_wr_en),
    .wr_addr(fp_wr_addr[4:2]),
    .wr_lane(fp_wr_lane),
    .wr_data(fp_wr_lanes),
    .rd_addr(fp_rd_addr[4:2]),
    .rd_data(fp_mem_q)
);

// ------------------------------------------------------------
// fp read formatting and source checks
// ------------------------------------------------------------
function automatic logic single_bad(input logic [31:0] v);
    logic [7:0] e;
    e = v[cpu_regs_pkg::SP_EXP_LO +: cpu_regs_pkg::SP_EXP_W];
    single_bad = (e == cpu_regs_pkg::SP_EXP_MAX) ||
        (e == 8'h00 && v[cpu_regs_pkg::SP_EXP_LO-1:0] != '0);
endfunction

function automatic logic double_bad(input logic [63:0] v);
    logic [10:0] e;
    e = v[cpu_regs_pkg::DP_EXP_LO +: cpu_regs_pkg::DP_EXP_W];
    double_bad = (e == cpu_regs_pkg::DP_EXP_MAX) ||
        (e == 11'h000 && v[cpu_regs_pkg::DP_EXP_LO-1:0] != '0);
endfunction

logic fp_pend;
logic fp_chk_q;
logic [1:0] fp_size_q;
logic [1:0] fp_lane_q;
logic [127:0] next_fp_rd;
logic next_fp_exc;

always_comb begin
    next_fp_rd = fp_mem_q;
    next_fp_exc = 1'b0;
    case (fp_size_q)
        cpu_regs_pkg::FP_32: begin
            next_fp_rd = {96'h0, fp_mem_q[fp_lane_q*32 +: 32]};
            next_fp_exc = single_bad(fp_mem_q[fp_lane_q*32 +: 32]);
        end
        cpu_regs_pkg::FP_64: begin
            next_fp_rd = {64'h0, fp_mem_q[fp_lane_q[1]*64 +: 64]};
            next_fp_exc = double_bad(fp_mem_q[fp_lane_q[1]*64 +: 64]);
        end
        default: begin
            next_fp_rd = fp_mem_q;
        end
    endcase
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        fp_pend <= 1'b0;
        fp_chk_q <= 1'b0;
        fp_size_q <= cpu_regs_pkg::FP_32;
        fp_lane_q <= 2'h0;
        fp_rd_valid <= 1'b0;
        fp_rd_data <= '0;
        fp_src_exc <= 1'b0;
    end else begin
        fp_pend <= fp_rd_req;
        fp_chk_q <= fp_rd_check;
        fp_size_q <= fp_rd_size;
        fp_lane_q <= fp_rd_addr[1:0];
        fp_rd_valid <= fp_pend;
        fp_rd_data <= next_fp_rd;
        fp_src_exc <= fp_pend && fp_chk_q && next_fp_exc;
    end
end

// ------------------------------------------------------------
// watch address match
// ------------------------------------------------------------
logic [31:0] acc_cmp_mask;
logic acc_hit;

always_comb begin
    case (acc_size)
        2'h0: acc_cmp_mask = 32'hffff_ffff;
        2'h1: acc_cmp_mask = 32'hffff_fffe;
        2'h2: acc_cmp_mask = 32'hffff_fffc;
        default: acc_cmp_mask = 32'hffff_fff8;
    endcase
    acc_hit = acc_valid &&
        ((acc_addr & acc_cmp_mask) == (watch_address_reg & acc_cmp_mask)) &&
        (acc_write
            ? processor_state_word[cpu_regs_pkg::PSW_STORE_MATCH]
            : processor_state_word[cpu_regs_pkg::PSW_LOAD_MATCH]);
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        acc_match_trap <= 1'b0;
    end else begin
        acc_match_trap <= acc_hit;
    end
end

// ------------------------------------------------------------
// interrupt gating
// ------------------------------------------------------------
logic ext_irq_gated;

assign ext_irq_gated = ext_irq_pin &&
    processor_state_word[cpu_regs_pkg::PSW_IRQ_EN];

always_ff @(posedge clk) begin
    if (!nrst) begin
        irq_request <= 1'b0;
    end else begin
        irq_request <= ext_irq_gated || parity_err || bus_fault_pin;
    end
end

// ------------------------------------------------------------
// control register writes
// ------------------------------------------------------------
logic user_mode;
logic psw_sw_wr;
logic [31:0] psw_wmask;

assign user_mode = processor_state_word[cpu_regs_pkg::PSW_USER];
assign psw_sw_wr = ctrl_wr_en && !ctrl_wr_sel;
assign psw_wmask = user_mode ? cpu_regs_pkg::PSW_USER_WMASK
    : ~cpu_regs_pkg::PSW_RSVD_MASK;

always_ff @(posedge clk) begin
    if (!nrst) begin
        watch_address_reg <= cpu_regs_pkg::WATCH_RESET;
    end else if (ctrl_wr_en && ctrl_wr_sel && !user_mode) begin
        watch_address_reg <= ctrl_wr_data;
    end
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        ctrl_wr_blocked <= 1'b0;
        privilege_user <= 1'b0;
    end else begin
        ctrl_wr_blocked <= ctrl_wr_en && user_mode &&
            (ctrl_wr_sel || (ctrl_wr_data & ~psw_wmask) != '0);
        privilege_user <= user_mode;
    end
end

// ------------------------------------------------------------
// processor state word
// ------------------------------------------------------------
logic [31:0] next_psw;
logic any_trap_flag;
logic fp_killing;

assign any_trap_flag = processor_state_word[cpu_regs_pkg::PSW_EXT_IRQ] ||
    processor_state_word[cpu_regs_pkg::PSW_OPCODE_TRAP] ||
    processor_state_word[cpu_regs_pkg::PSW_FETCH_TRAP] ||
    processor_state_word[cpu_regs_pkg::PSW_OPERAND_TRAP] ||
    processor_state_word[cpu_regs_pkg::PSW_FP_TRAP];
assign fp_killing = fp_issue &&
    processor_state_word[cpu_regs_pkg::PSW_SKIP_FP];

always_comb begin
    next_psw = processor_state_word;
    if (psw_sw_wr) begin
        next_psw = (processor_state_word & ~psw_wmask) |
            (ctrl_wr_data & psw_wmask);
    end
    if (fp_killing) begin
        next_psw[cpu_regs_pkg::PSW_SKIP_FP] = 1'b0;
    end
    if (rshift_exec) begin
        next_psw[cpu_regs_pkg::PSW_SHIFT_LO +: cpu_regs_pkg::PSW_SHIFT_W] =
            rshift_count;
    end
    if (trap_return && any_trap_flag) begin
        next_psw[cpu_regs_pkg::PSW_IRQ_EN] =
            processor_state_word[cpu_regs_pkg::PSW_PRIOR_IRQ];
        next_psw[cpu_regs_pkg::PSW_USER] =
            processor_state_word[cpu_regs_pkg::PSW_PRIOR_USER];
    end
    if (trap_take) begin
        next_psw[cpu_regs_pkg::PSW_PRIOR_IRQ] =
            processor_state_word[cpu_regs_pkg::PSW_IRQ_EN];
        next_psw[cpu_regs_pkg::PSW_PRIOR_USER] =
            processor_state_word[cpu_regs_pkg::PSW_USER];
        next_psw[cpu_regs_pkg::PSW_IRQ_EN] = 1'b0;
        next_psw[cpu_regs_pkg::PSW_USER] = 1'b0;
        next_psw[cpu_regs_pkg::PSW_DUAL] = dual_mode_now;
        next_psw[cpu_regs_pkg::PSW_DEFER_SWAP] = mode_change_next;
    end
    // hardware sets win over a same-cycle software clear
    if (trap_cause[0] || fp_src_exc) begin
        next_psw[cpu_regs_pkg::PSW_FP_TRAP] = 1'b1;
    end
    if (trap_cause[1] || acc_match_trap) begin
        next_psw[cpu_regs_pkg::PSW_OPERAND_TRAP] = 1'b1;
    end
    if (trap_cause[2]) begin
        next_psw[cpu_regs_pkg::PSW_FETCH_TRAP] = 1'b1;
    end
    if (trap_cause[3]) begin
        next_psw[cpu_regs_pkg::PSW_OPCODE_TRAP] = 1'b1;
    end
    if (ext_irq_gated) begin
        next_psw[cpu_regs_pkg::PSW_EXT_IRQ] = 1'b1;
    end
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        processor_state_word <= cpu_regs_pkg::PSW_RESET;
    end else begin
        processor_state_word <= next_psw;
    end
end

// ------------------------------------------------------------
// return mode and fp kill
// ------------------------------------------------------------
always_ff @(posedge clk) begin
    if (!nrst) begin
        resume_dual <= 1'b0;
        resume_swap <= 1'b0;
        fp_kill <= 1'b0;
        fp_kill_dual <= 1'b0;
    end else begin
        if (trap_return) begin
            resume_dual <= processor_state_word[cpu_regs_pkg::PSW_DUAL];
            resume_swap <=
                processor_state_word[cpu_regs_pkg::PSW_DEFER_SWAP];
        end
        fp_kill <= fp_killing;
        fp_kill_dual <= fp_killing && fp_issue_dual;
    end
end

// ------------------------------------------------------------
// masked pixel store byte enables
// ------------------------------------------------------------
logic [1:0] pix_width;
logic [7:0] pix_mask;
logic [7:0] next_pix_en;

assign pix_width = processor_state_word[cpu_regs_pkg::PSW_PIX_LO +: 2];
assign pix_mask =
    processor_state_word[cpu_regs_pkg::PSW_MASK_LO +: cpu_regs_pkg::PSW_MASK_W];

always_comb begin
    case (pix_width)
        cpu_regs_pkg::PIX_8: next_pix_en = pix_mask;
        cpu_regs_pkg::PIX_16: next_pix_en = {{2{pix_mask[3]}},
            {2{pix_mask[2]}}, {2{pix_mask[1]}}, {2{pix_mask[0]}}};
        cpu_regs_pkg::PIX_32: next_pix_en = {{4{pix_mask[1]}},
            {4{pix_mask[0]}}};
        default: next_pix_en = 8'h00;
    endcase
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        pix_byte_en <= 8'h00;
    end else begin
        pix_byte_en <= pix_store_req ? next_pix_en : 8'h00;
    end
end

endmodule

`default_nettype wire

// ---- cpu_regs_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpu_regs_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] int_rd_addr,
    input wire logic [31:0] int_rd_data,
    input wire logic store_req,
    input wire logic store_valid,
    input wire logic fp_rd_req,
    input wire logic fp_rd_valid,
    input wire logic [31:0] processor_state_word,
    input wire logic [31:0] watch_address_reg,
    input wire logic ctrl_wr_en,
    input wire logic ctrl_wr_sel,
    input wire logic ctrl_wr_blocked,
    input wire logic ext_irq_pin,
    input wire logic parity_err,
    input wire logic bus_fault_pin,
    input wire logic irq_request,
    input wire logic trap_take,
    input wire logic trap_return,
    input wire logic fp_issue,
    input wire logic fp_issue_dual,
    input wire logic fp_kill,
    input wire logic fp_kill_dual,
    input wire logic rshift_exec,
    input wire logic [4:0] rshift_count
);
// ----------
// port relations
// ----------
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
a_int_zero_read: assert property (
    $past(nrst) && $past(int_rd_addr) == 5'h0 |-> int_rd_data == 32'h0)
    else $error("register zero read nonzero");
a_store_answer: assert property (
    store_req |-> ##2 store_valid) else $error("store answer late");
a_fp_read_answer: assert property (
    fp_rd_req |-> ##2 fp_rd_valid) else $error("fp read answer late");
a_irq_gating: assert property (
    $past(nrst) |-> irq_request == ($past(ext_irq_pin)
    & $past(processor_state_word[4]) | $past(parity_err)
    | $past(bus_fault_pin))) else $error("irq gating wrong");
a_trap_saves_modes: assert property (
    trap_take && !ctrl_wr_en && !trap_return |=> processor_state_word[7:4]
    == {$past(processor_state_word[6]), 1'b0,
    $past(processor_state_word[4]), 1'b0}) else $error("trap save wrong");
a_user_write_block: assert property (
    ctrl_wr_en && ctrl_wr_sel && processor_state_word[6]
    |=> ctrl_wr_blocked && $stable(watch_address_reg))
    else $error("user write not blocked");
a_skip_fp_kill: assert property (
    fp_issue && processor_state_word[15]
    |=> fp_kill && fp_kill_dual == $past(fp_issue_dual))
    else $error("fp op not killed");
a_shift_capture: assert property (
    rshift_exec && !ctrl_wr_en
    |=> processor_state_word[21:17] == $past(rshift_count))
    else $error("shift count not captured");
endmodule

bind cpu_register_set_status cpu_regs_monitor u_mon (.*);
`default_nettype wire

// ---- test_cpu_register_set_status.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_cpu_register_set_status;
logic clk = 1'b0;
logic nrst = 1'b0;
logic [4:0] int_wr_addr = '0, int_rd_addr = '0, fp_wr_addr = '0;
logic [4:0] fp_rd_addr = '0, rshift_count = '0;
logic [1:0] int_wr_size = '0, store_size = '0, fp_wr_size = '0;
logic [1:0] fp_rd_size = '0, acc_size = '0;
logic [31:0] int_wr_data = '0, ctrl_wr_data = '0, acc_addr = '0;
logic [127:0] fp_wr_data = '0;
logic [3:0] trap_cause = '0;
logic int_wr_en = 0, store_req = 0, fp_wr_en = 0, fp_rd_req = 0;
logic fp_rd_check = 0, ctrl_wr_en = 0, ctrl_wr_sel = 0, ext_irq_pin = 0;
logic parity_err = 0, bus_fault_pin = 0, trap_take = 0, dual_mode_now = 0;
logic mode_change_next = 0, trap_return = 0, fp_issue = 0;
logic fp_issue_dual = 0, rshift_exec = 0, acc_valid = 0, acc_write = 0;
logic pix_store_req = 0;
logic [31:0] int_rd_data, store_data, processor_state_word;
logic [31:0] watch_address_reg;
logic [127:0] fp_rd_data;
logic [7:0] pix_byte_en;
logic store_valid, fp_rd_valid, fp_src_exc, ctrl_wr_blocked;
logic privilege_user, irq_request, resume_dual, resume_swap, fp_kill;
logic fp_kill_dual, acc_match_trap;
int error_cnt = 0;
int cmp_count = 0;
int cycles = 0;

cpu_register_set_status DUT (.*);

always #5 clk = ~clk;

always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
        error_cnt++;
        test_done();
    end
end

// ----------
// access tasks
// ----------
task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        error_cnt++;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
endtask

task automatic step;
    @(negedge clk);
endtask

task automatic pchk(input logic [31:0] exp);
    chk(processor_state_word & 32'hffff_feff, exp);
endtask

task automatic iwr(input logic [4:0] a, input logic [1:0] s,
                   input logic [31:0] d);
    int_wr_en = 1'b1;
    int_wr_addr = a;
    int_wr_size = s;
    int_wr_data = d;
    step();
    int_wr_en = 1'b0;
endtask

task automatic ird(input logic [4:0] a, input logic [31:0] e);
    int_rd_addr = a;
    step();
    chk(int_rd_data, e);
endtask

task automatic ist(input logic [4:0] a, input logic [1:0] s,
                   input logic [31:0] e);
    int_rd_addr = a;
    store_req = 1'b1;
    store_size = s;
    step();
    store_req = 1'b0;
    step();
    chk(store_valid, 1'b1);
    chk(store_data, e);
endtask

task automatic fwr(input logic [4:0] a, input logic [1:0] s,
                   input logic [127:0] d);
    fp_wr_en = 1'b1;
    fp_wr_addr = a;
    fp_wr_size = s;
    fp_wr_data = d;
    step();
    fp_wr_en = 1'b0;
endtask

task automatic frd(input logic [4:0] a, input logic [1:0] s,
                   input logic [127:0] e, input logic x);
    logic [127:0] m;
    m = (s == 2'h0) ? 128'hffff_ffff : (s == 2'h1) ? {64'h0, {64{1'b1}}}
        : {128{1'b1}};
    fp_rd_req = 1'b1;
    fp_rd_addr = a;
    fp_rd_size = s;
    fp_rd_check = 1'b1;
    step();
    fp_rd_req = 1'b0;
    step();
    chk(fp_rd_valid, 1'b1);
    chk(fp_rd_data & m, e);
    chk(fp_src_exc, x);
endtask

task automatic cwr(input logic sel, input logic [31:0] d);
    ctrl_wr_en = 1'b1;
    ctrl_wr_sel = sel;
    ctrl_wr_data = d;
    step();
    ctrl_wr_en = 1'b0;
endtask

task automatic trap(input logic dm, input logic mc, input logic [3:0] c);
    trap_take = 1'b1;
    dual_mode_now = dm;
    mode_change_next = mc;
    trap_cause = c;
    step();
    trap_take = 1'b0;
    trap_cause = 4'h0;
endtask

task automatic pix(input logic [7:0] msk, input logic [1:0] w,
                   input logic [7:0] e);
    cwr(1'b0, {msk, w, 22'h0});
    pix_store_req = 1'b1;
    step();
    pix_store_req = 1'b0;
    chk(pix_byte_en, e);
endtask

task automatic acc(input logic w, input logic [1:0] s,
                   input logic [31:0] a, input logic e);
    acc_valid = 1'b1;
    acc_write = w;
    acc_size = s;
    acc_addr = a;
    step();
    acc_valid = 1'b0;
    chk(acc_match_trap, e);
    step();
endtask

// ----------
// main sequence
// ----------
initial begin
    repeat (16) step();
    nrst = 1'b1;
    pchk(32'h0);
    iwr(5'h05, 2'h0, 32'h0000_0080);
    ird(5'h05, 32'hffff_ff80);
    iwr(5'h05, 2'h1, 32'h1234_8001);
    ird(5'h05, 32'hffff_8001);
    iwr(5'h00, 2'h2, 32'hdead_beef);
    ird(5'h00, 32'h0);
    iwr(5'h1f, 2'h2, 32'h1234_5678);
    ird(5'h1f, 32'h1234_5678);
    ist(5'h1f, 2'h0, 32'h0000_0078);
    ist(5'h1f, 2'h1, 32'h0000_5678);
    ist(5'h1f, 2'h2, 32'h1234_5678);
    fwr(5'h04, 2'h2, 128'h7777_6666_5555_4444_3333_2222_1111_0000);
    frd(5'h04, 2'h2, 128'h7777_6666_5555_4444_3333_2222_1111_0000, 0);
    fwr(5'h00, 2'h2, 128'h7777_6666_5555_4444_3333_2222_1111_0000);
    frd(5'h00, 2'h2, 128'h7777_6666_5555_4444_0000_0000_0000_0000, 0);
    fwr(5'h0a, 2'h1, 128'h89ab_cdef_0123_4567);
    frd(5'h0a, 2'h1, 128'h89ab_cdef_0123_4567, 1'b0);
    frd(5'h0b, 2'h0, 128'h89ab_cdef, 1'b0);
    frd(5'h0a, 2'h0, 128'h0123_4567, 1'b0);
    fwr(5'h08, 2'h0, 128'h7f80_0000);
    frd(5'h08, 2'h0, 128'h7f80_0000, 1'b1);
    fwr(5'h08, 2'h0, 128'h0000_0001);
    frd(5'h08, 2'h0, 128'h0000_0001, 1'b1);
    fwr(5'h08, 2'h0, 128'h3f80_0000);
    frd(5'h08, 2'h0, 128'h3f80_0000, 1'b0);
    fwr(5'h08, 2'h1, 128'h7ff0_0000_0000_0000);
    frd(5'h08, 2'h1, 128'h7ff0_0000_0000_0000, 1'b1);
    fwr(5'h08, 2'h1, 128'h1);
    frd(5'h08, 2'h1, 128'h1, 1'b1);
    fwr(5'h08, 2'h1, 128'h3ff0_0000_0000_0000);
    frd(5'h08, 2'h1, 128'h3ff0_0000_0000_0000, 1'b0);
    cwr(1'b0, 32'h0000_0050);
    step();
    chk(privilege_user, 1'b1);
    ext_irq_pin = 1'b1;
    step();
    chk(irq_request, 1'b1);
    ext_irq_pin = 1'b0;
    cwr(1'b1, 32'h0000_0100);
    chk(ctrl_wr_blocked, 1'b1);
    chk(watch_address_reg, 32'h0);
    step();
    cwr(1'b0, 32'hffff_ffff);
    pchk(32'h0000_005c);
    trap(1'b1, 1'b1, 4'h1);
    pchk(32'h0000_70ac);
    ext_irq_pin = 1'b1;
    step();
    chk(irq_request, 1'b0);
    parity_err = 1'b1;
    step();
    chk(irq_request, 1'b1);
    parity_err = 1'b0;
    bus_fault_pin = 1'b1;
    step();
    chk(irq_request, 1'b1);
    bus_fault_pin = 1'b0;
    ext_irq_pin = 1'b0;
    trap_return = 1'b1;
    step();
    trap_return = 1'b0;
    pchk(32'h0000_70fc);
    chk({resume_dual, resume_swap}, 2'h3);
    trap(1'b0, 1'b0, 4'h0);
    pchk(32'h0000_10ac);
    cwr(1'b0, 32'h0);
    for (int i = 0; i < 4; i++) begin
        trap_cause = 4'h1 << i;
        step();
        trap_cause = 4'h0;
        chk(processor_state_word[12-i], 1'b1);
        cwr(1'b0, 32'h0);
    end
    step();
    cwr(1'b0, 32'h0000_8000);
    fp_issue = 1'b1;
    fp_issue_dual = 1'b1;
    step();
    fp_issue_dual = 1'b0;
    chk({fp_kill, fp_kill_dual, processor_state_word[15]}, 3'h6);
    step();
    fp_issue = 1'b0;
    chk(fp_kill, 1'b0);
    rshift_exec = 1'b1;
    rshift_count = 5'h1b;
    step();
    rshift_exec = 1'b0;
    chk(processor_state_word[21:17], 5'h1b);
    pix(8'ha5, 2'h0, 8'ha5);
    pix(8'hf6, 2'h1, 8'h3c);
    pix(8'hfe, 2'h2, 8'hf0);
    pix(8'hff, 2'h3, 8'h00);
    cwr(1'b1, 32'h0000_0100);
    chk(watch_address_reg, 32'h0000_0100);
    step();
    cwr(1'b0, 32'h0000_0001);
    acc(1'b0, 2'h2, 32'h0000_0102, 1'b1);
    acc(1'b1, 2'h2, 32'h0000_0100, 1'b0);
    acc(1'b0, 2'h0, 32'h0000_0101, 1'b0);
    cwr(1'b0, 32'h0000_0002);
    acc(1'b1, 2'h1, 32'h0000_0101, 1'b1);
    acc(1'b0, 2'h1, 32'h0000_0100, 1'b0);
    acc(1'b1, 2'h3, 32'h0000_0107, 1'b1);
    test_done();
end
endmodule
`default_nettype wire
